// ===== lpwt_pkg.sv
package lpwt_pkg;

  // ****************************************************
  // Timer register offsets on the device interface
  // ****************************************************
  localparam logic [7:0] LPWT_OFS_CTRL1 = 8'hb0; // timer_control_one
  localparam logic [7:0] LPWT_OFS_CTRL2 = 8'hb1; // timer_control_two
  localparam logic [7:0] LPWT_OFS_CTRL3 = 8'hb2; // timer_control_three
  localparam logic [7:0] LPWT_OFS_PERIOD = 8'hb4; // period_value
  localparam logic [7:0] LPWT_OFS_CMP = 8'hb8; // compare_zero_value
  localparam logic [7:0] LPWT_OFS_WAKE = 8'hbc; // wakeup_control

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int LPWT_DIV_LSB = 0; // divider_select[2:0]
  localparam int LPWT_SRC_BIT = 3; // source_select
  localparam int LPWT_CMPE_BIT = 4; // compare_zero_enable
  localparam int LPWT_STOP_BIT = 0; // counter_stop
  localparam int LPWT_CEN_BIT = 0; // count_enable
  localparam int LPWT_CLR_BIT = 1; // counter_clear
  localparam int LPWT_WKEN_BIT = 15; // standby_wakeup_enable

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic [2:0] LPWT_RST_DIV = 3'h0;
  localparam logic LPWT_RST_STOP = 1'b1;
  localparam logic [15:0] LPWT_RST_PERIOD = 16'hffff;
  localparam logic [15:0] LPWT_RST_CMP = 16'hffff;

  // Event number of the compare-match event
  localparam logic [7:0] LPWT_EVENT_NUM = 8'h5d;

  // ****************************************************
  // Controller APB map and fields
  // ****************************************************
  localparam logic [11:0] LPWT_APB_TADDR = 12'h000;
  localparam logic [11:0] LPWT_APB_TDATA = 12'h004;
  localparam logic [11:0] LPWT_APB_SYS = 12'h008;
  localparam logic [11:0] LPWT_APB_ELSEL = 12'h00c;
  localparam logic [11:0] LPWT_APB_STAT = 12'h010;
  localparam logic [11:0] LPWT_APB_MASK = 12'h014;
  localparam int LPWT_PROT_BIT = 0; // write_protect_enable_timer
  localparam int LPWT_PWR_LSB = 1; // power state [2:1]
  localparam int LPWT_WDTH_BIT = 3; // watchdog halts in low power
  localparam int LPWT_ST_EVT = 0; // compare event seen
  localparam int LPWT_ST_WAKE = 1; // wakeup happened

  // Chip power states
  typedef enum logic [1:0] {
    LPWT_NORMAL = 2'b00,
    LPWT_SLEEP = 2'b01,
    LPWT_DEEP = 2'b10,
    LPWT_STANDBY = 2'b11
  } lpwt_pwr_t;

endpackage : lpwt_pkg

// ===== lpwt_if.sv
`timescale 1ns/100ps
interface lpwt_if;
  logic wr_en; // One-cycle register write strobe
  logic [7:0] addr; // Register offset, write and read
  logic [15:0] wr_data; // Write data
  logic [15:0] rd_data; // Registered read data of addr
  logic protect_en; // Writes allowed only while high
  lpwt_pkg::lpwt_pwr_t power_state; // Chip power state
  logic wdt_halt; // Watchdog oscillator stops in low power
  logic src_tick; // Pulse per selected source edge
  logic cmp_event; // Compare-match event pulse
  logic wake_req; // Wakeup request pulse

  // Timer end
  modport dev (
    input wr_en, addr, wr_data, protect_en, power_state, wdt_halt,
    output rd_data, src_tick, cmp_event, wake_req
  );

  // Controller end
  modport ctl (
    output wr_en, addr, wr_data, protect_en, power_state, wdt_halt,
    input rd_data, src_tick, cmp_event, wake_req
  );
endinterface : lpwt_if

// ===== lpwt_timer.sv
`timescale 1ns/100ps

// Operation
// - One 16-bit up-counter, runs in all states
// - Count clock is source divided 2..32
// - Source select 1 picks watchdog oscillator
// - Clear stop, then set enable to count
// - Period match wraps counter to zero
// - Compare match in standby wakes processor
// - Compare event only in software standby
// - Halted watchdog oscillator stops the counter
// - Writing clear bit zeroes the counter
// - Clear bit returns to zero when done
// - Software clears counter only while disabled
// - Wait one source cycle before standby again
// - Event selector loaded with number 5Dh
// - Writes need write-protect enable set
// - Compare value below period value
// - No compare writes while counting
module lpwt_timer (
  input wire logic pclk,
  input wire logic presetn,
  lpwt_if.dev link,
  input wire logic sub_osc,
  input wire logic wdt_osc,
  output logic [15:0] count_value
);
  import lpwt_pkg::*;

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    logic [2:0] sub_sync; // Sub-clock synchroniser and edge
    logic [2:0] wdt_sync; // Watchdog osc synchroniser and edge
    logic [4:0] pre; // Prescaler of source edges
    logic [15:0] cnt; // The counter
    logic [2:0] div_sel; // divider_select
    logic src_sel; // source_select
    logic cmp_en; // compare_zero_enable
    logic stop; // counter_stop
    logic cen; // count_enable
    logic clr; // counter_clear, self clearing
    logic [15:0] period; // period_value
    logic [15:0] cmp; // compare_zero_value
    logic wken; // standby_wakeup_enable
    logic [15:0] rd_data; // Registered read data
    logic src_tick; // Selected source edge pulse
    logic cmp_event; // Compare-match event pulse
    logic wake_req; // Wakeup request pulse
  } lpwt_tmr_t;

  lpwt_tmr_t s; // Current state
  lpwt_tmr_t next_s; // Next state

  // Prescaler mask per divide select; codes 4 and above act as /32
  function automatic logic [4:0] div_mask(input logic [2:0] sel);
    logic [4:0] m;
    m = 5'h1f;
    unique case (sel)
      3'h0: m = 5'h01;
      3'h1: m = 5'h03;
      3'h2: m = 5'h07;
      3'h3: m = 5'h0f;
      default: m = 5'h1f;
    endcase
    return m;
  endfunction : div_mask

  // Read mux of the six registers, unmapped offsets read zero
  function automatic logic [15:0] rd_mux(input lpwt_tmr_t t,
                                         input logic [7:0] a);
    logic [15:0] d;
    d = 16'h0000;
    unique case (a)
      LPWT_OFS_CTRL1: begin
        d[LPWT_DIV_LSB +: 3] = t.div_sel;
        d[LPWT_SRC_BIT] = t.src_sel;
        d[LPWT_CMPE_BIT] = t.cmp_en;
      end
      LPWT_OFS_CTRL2: d[LPWT_STOP_BIT] = t.stop;
      LPWT_OFS_CTRL3: begin
        d[LPWT_CEN_BIT] = t.cen;
        d[LPWT_CLR_BIT] = t.clr;
      end
      LPWT_OFS_PERIOD: d = t.period;
      LPWT_OFS_CMP: d = t.cmp;
      LPWT_OFS_WAKE: d[LPWT_WKEN_BIT] = t.wken;
      default: d = 16'h0000;
    endcase
    return d;
  endfunction : rd_mux

  // ****************************************************
  // Next-state logic
  // ****************************************************

  // Oscillator edges come from the second and third flops only
  always_comb begin
    logic sub_rise;
    logic wdt_rise;
    logic low_power;
    logic src_rise;
    logic running;
    logic tick;
    logic [15:0] cnt_nx;
    sub_rise = 1'b0;
    wdt_rise = 1'b0;
    low_power = 1'b0;
    src_rise = 1'b0;
    running = 1'b0;
    tick = 1'b0;
    cnt_nx = 16'h0000;
    next_s = s;
    next_s.cmp_event = 1'b0;
    next_s.wake_req = 1'b0;

    // Two flops before any logic, third one for edge finding
    next_s.sub_sync = {s.sub_sync[1:0], sub_osc};
    next_s.wdt_sync = {s.wdt_sync[1:0], wdt_osc};
    sub_rise = s.sub_sync[1] & ~s.sub_sync[2];
    wdt_rise = s.wdt_sync[1] & ~s.wdt_sync[2];

    // Pick the source; a halted watchdog oscillator gives no edges
    low_power = (link.power_state != LPWT_NORMAL);
    if (s.src_sel) begin
      src_rise = wdt_rise & ~(link.wdt_halt & low_power);
    end else begin
      src_rise = sub_rise;
    end
    next_s.src_tick = src_rise;

    // Counting needs stop cleared and enable set
    running = s.cen & ~s.stop;

    // Prescaler; tick when the selected low bits are all ones
    tick = 1'b0;
    if (running && src_rise) begin
      next_s.pre = s.pre + 5'h01;
      tick = ((s.pre & div_mask(s.div_sel)) == div_mask(s.div_sel));
    end

    // Counter step; power state gates it only through the watchdog halt
    cnt_nx = s.cnt;
    if (tick) begin
      if (s.cnt == s.period) begin
        cnt_nx = 16'h0000;
      end else begin
        cnt_nx = s.cnt + 16'h0001;
      end
    end
    next_s.cnt = cnt_nx;

    // Compare match only reported in software standby
    if (tick && (cnt_nx == s.cmp) && s.cmp_en &&
        (link.power_state == LPWT_STANDBY)) begin
      next_s.cmp_event = 1'b1;
      next_s.wake_req = s.wken;
    end

    // Pending clear is done on the next source edge
    if (s.clr && src_rise) begin
      next_s.cnt = 16'h0000;
      next_s.pre = 5'h00;
      next_s.clr = 1'b0;
    end

    // Register writes, dropped while protection is off
    if (link.wr_en && link.protect_en) begin
      unique case (link.addr)
        LPWT_OFS_CTRL1: begin
          next_s.div_sel = link.wr_data[LPWT_DIV_LSB +: 3];
          next_s.src_sel = link.wr_data[LPWT_SRC_BIT];
          next_s.cmp_en = link.wr_data[LPWT_CMPE_BIT];
        end
        LPWT_OFS_CTRL2: next_s.stop = link.wr_data[LPWT_STOP_BIT];
        LPWT_OFS_CTRL3: begin
          next_s.cen = link.wr_data[LPWT_CEN_BIT];
          // Writing zero does not cancel a clear in flight
          if (link.wr_data[LPWT_CLR_BIT]) begin
            next_s.clr = 1'b1;
          end
        end
        LPWT_OFS_PERIOD: next_s.period = link.wr_data;
        LPWT_OFS_CMP: next_s.cmp = link.wr_data;
        LPWT_OFS_WAKE: next_s.wken = link.wr_data[LPWT_WKEN_BIT];
        default: next_s.rd_data = s.rd_data; // Unmapped, ignored
      endcase
    end

    // Read data registered from the current offset
    next_s.rd_data = rd_mux(s, link.addr);
  end

  // ****************************************************
  // State register
  // ****************************************************

  // Only constants under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.div_sel <= LPWT_RST_DIV;
      s.stop <= LPWT_RST_STOP;
      s.period <= LPWT_RST_PERIOD;
      s.cmp <= LPWT_RST_CMP;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign link.rd_data = s.rd_data;
  assign link.src_tick = s.src_tick;
  assign link.cmp_event = s.cmp_event;
  assign link.wake_req = s.wake_req;
  assign count_value = s.cnt;

endmodule : lpwt_timer

// ===== lpwt_ctrl.sv
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module lpwt_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic event_out,
  lpwt_if.ctl link
);
  import lpwt_pkg::*;

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    logic [7:0] taddr; // Timer register offset
    logic prot; // write_protect_enable_timer
    lpwt_pwr_t pwr; // Power state
    logic wdt_halt; // Watchdog halts in low power
    logic [7:0] elsel; // event_selector_nineteen
    logic [1:0] stat; // Sticky status
    logic [1:0] mask; // Interrupt mask
    logic sh_cen; // Shadow of count_enable
    logic sh_stop; // Shadow of counter_stop
    logic [15:0] sh_period; // Shadow of period_value
    logic guard; // Standby entry blocked after wake
    logic stby_pend; // Deferred standby request
    logic wr_en; // Timer write strobe
    logic [15:0] wr_data; // Timer write data
    logic [31:0] prdata; // APB read data
    logic pslverr; // APB error
    logic evt; // Routed event pulse
  } lpwt_ctl_t;

  lpwt_ctl_t s; // Current state
  lpwt_ctl_t next_s; // Next state

  // ****************************************************
  // Next-state logic
  // ****************************************************
  always_comb begin
    logic setup;
    logic wr;
    logic hit;
    logic wake;
    logic [15:0] d;
    logic [31:0] r;
    logic bad;
    setup = psel & ~penable;
    wr = psel & penable & pwrite;
    hit = 1'b0;
    wake = 1'b0;
    d = pwdata[15:0];
    r = 32'h00000000;
    bad = 1'b0;
    next_s = s;
    next_s.wr_en = 1'b0;

    // Route the event only from the right selector number
    hit = link.cmp_event & (s.elsel == LPWT_EVENT_NUM);
    wake = link.wake_req & hit & (s.pwr == LPWT_STANDBY);
    next_s.evt = hit;

    // Source cycle seen since wake releases the guard
    if (link.src_tick) begin
      next_s.guard = 1'b0;
    end
    if (wake) begin
      next_s.pwr = LPWT_NORMAL;
      next_s.guard = 1'b1;
    end

    // Sticky status, w1c, set wins
    if (wr && paddr == LPWT_APB_STAT) begin
      next_s.stat = s.stat & ~pwdata[1:0];
    end
    if (hit) begin
      next_s.stat[LPWT_ST_EVT] = 1'b1;
    end
    if (wake) begin
      next_s.stat[LPWT_ST_WAKE] = 1'b1;
    end

    // Deferred standby once guard clears
    if (s.stby_pend && !next_s.guard) begin
      next_s.pwr = LPWT_STANDBY;
      next_s.stby_pend = 1'b0;
    end

    // APB writes at access edge, pready always high
    if (wr) begin
      unique case (paddr)
        LPWT_APB_TADDR: next_s.taddr = pwdata[7:0];
        LPWT_APB_SYS: begin
          next_s.prot = pwdata[LPWT_PROT_BIT];
          next_s.wdt_halt = pwdata[LPWT_WDTH_BIT];
          if (lpwt_pwr_t'(pwdata[LPWT_PWR_LSB +: 2]) == LPWT_STANDBY &&
              next_s.guard) begin
            next_s.stby_pend = 1'b1;
          end else begin
            next_s.pwr = lpwt_pwr_t'(pwdata[LPWT_PWR_LSB +: 2]);
            next_s.stby_pend = 1'b0;
          end
        end
        LPWT_APB_ELSEL: next_s.elsel = pwdata[7:0];
        LPWT_APB_MASK: next_s.mask = pwdata[1:0];
        LPWT_APB_TDATA: begin
          next_s.wr_en = 1'b1;
          unique case (s.taddr)
            LPWT_OFS_CTRL2: begin
              if (s.prot) begin
                next_s.sh_stop = d[LPWT_STOP_BIT];
              end
            end
            LPWT_OFS_CTRL3: begin
              if (s.sh_stop) begin
                d[LPWT_CEN_BIT] = 1'b0;
              end
              if (s.sh_cen || d[LPWT_CEN_BIT]) begin
                d[LPWT_CLR_BIT] = 1'b0;
              end
              if (s.prot) begin
                next_s.sh_cen = d[LPWT_CEN_BIT];
              end
            end
            LPWT_OFS_PERIOD: begin
              if (s.prot) begin
                next_s.sh_period = d;
              end
            end
            LPWT_OFS_CMP: begin
              // Below period and only while count_enable is clear
              if (s.sh_cen || d >= s.sh_period) begin
                next_s.wr_en = 1'b0;
              end
            end
            LPWT_OFS_WAKE: begin
              if (s.sh_cen) begin
                next_s.wr_en = 1'b0;
              end
            end
            default: next_s.wr_en = 1'b1;
          endcase
        end
        default: next_s.wr_en = 1'b0; // Unmapped write ignored
      endcase
    end
    next_s.wr_data = d;

    // Read data and error prepared in the setup cycle
    unique case (paddr)
      LPWT_APB_TADDR: r[7:0] = s.taddr;
      LPWT_APB_TDATA: r[15:0] = link.rd_data;
      LPWT_APB_SYS: begin
        r[LPWT_PROT_BIT] = s.prot;
        r[LPWT_PWR_LSB +: 2] = s.pwr;
        r[LPWT_WDTH_BIT] = s.wdt_halt;
      end
      LPWT_APB_ELSEL: r[7:0] = s.elsel;
      LPWT_APB_STAT: r[1:0] = s.stat;
      LPWT_APB_MASK: r[1:0] = s.mask;
      default: bad = 1'b1;
    endcase
    if (setup) begin
      next_s.prdata = pwrite ? 32'h00000000 : r;
      next_s.pslverr = bad;
    end
  end

  // ****************************************************
  // State register
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.sh_stop <= LPWT_RST_STOP;
      s.sh_period <= LPWT_RST_PERIOD;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign prdata = s.prdata;
  assign pready = 1'b1;
  assign pslverr = s.pslverr & psel & penable;
  assign irq = |(s.stat & s.mask);
  assign event_out = s.evt;
  assign link.wr_en = s.wr_en;
  assign link.addr = s.taddr;
  assign link.wr_data = s.wr_data;
  assign link.protect_en = s.prot;
  assign link.power_state = s.pwr;
  assign link.wdt_halt = s.wdt_halt;

endmodule : lpwt_ctrl

// ===== lpwt_chk.sv
`timescale 1ns/100ps
module lpwt_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [7:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic [15:0] rd_data,
  input wire logic protect_en,
  input wire lpwt_pkg::lpwt_pwr_t power_state,
  input wire logic wdt_halt,
  input wire logic src_tick,
  input wire logic cmp_event,
  input wire logic wake_req
);
  import lpwt_pkg::*;

  // ****************
  // Shadow of timer settings seen on the link
  // ****************
  typedef struct packed {
    logic src_wdt; // Watchdog oscillator chosen
    logic wake_en; // Wakeup enabled
  } lpwt_chk_t;
  lpwt_chk_t st, next_st;
  logic wr_ok; // Write that the timer accepts
  assign wr_ok = wr_en && protect_en;

  // Follow only accepted writes, as the timer does
  always_comb begin
    next_st = st;
    if (wr_ok && addr == LPWT_OFS_CTRL1) begin
      next_st.src_wdt = wr_data[LPWT_SRC_BIT];
    end
    if (wr_ok && addr == LPWT_OFS_WAKE) begin
      next_st.wake_en = wr_data[LPWT_WKEN_BIT];
    end
  end

  // Register the shadow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ****************
  // Assertions
  // ****************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Halted watchdog source while in a low-power state
  sequence halted_s;
    st.src_wdt && wdt_halt && power_state != LPWT_NORMAL;
  endsequence
  // Clear pending on the read-back of the third control
  sequence clr_wait_s;
    addr == LPWT_OFS_CTRL3 && rd_data[LPWT_CLR_BIT] && src_tick;
  endsequence

  a_event_in_standby: assert property (
    cmp_event |-> $past(power_state) == LPWT_STANDBY)
    else $error("compare event outside standby");
  a_event_single: assert property (
    cmp_event |=> !cmp_event)
    else $error("compare event longer than one cycle");
  a_wake_cause: assert property (
    wake_req |-> cmp_event && st.wake_en)
    else $error("wakeup without enabled compare event");
  a_event_wakes: assert property (
    cmp_event && st.wake_en |-> wake_req)
    else $error("enabled compare event gave no wakeup");
  a_wake_to_normal: assert property (
    wake_req |-> ##[1:3] power_state == LPWT_NORMAL)
    else $error("wakeup did not return to normal");
  a_halt_no_tick: assert property (
    halted_s [*6] |-> !src_tick)
    else $error("tick from halted watchdog oscillator");
  a_locked_no_write: assert property (
    wr_en && !protect_en && addr == LPWT_OFS_PERIOD
    |=> $stable(rd_data) [*3])
    else $error("protected period register changed");
  a_clear_self_ends: assert property (
    clr_wait_s |-> ##[1:4] !rd_data[LPWT_CLR_BIT])
    else $error("clear bit did not return to zero");

  // Wakeup scenario reached
  c_wake: cover property (wake_req);
endmodule : lpwt_chk

// ===== lpwt_test.sv
`timescale 1ns/100ps
module lpwt_test;
  import lpwt_pkg::*;

  // ****************
  // Signals and instances
  // ****************
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic sub_osc = 0;
  logic wdt_osc = 0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, irq, event_out, rerr;
  logic [15:0] count_value, rv;
  int n_mismatch = 0;
  int checks = 0;
  int ocnt = 0; // Oscillator divider
  // Row: protect, offset, write value, read-back
  typedef struct {
    logic p;
    logic [7:0] o;
    logic [15:0] w, e;
  } lpwt_row_t;
  lpwt_row_t rows[6] = '{
    '{1'b1, LPWT_OFS_PERIOD, 16'h0010, 16'h0010},
    '{1'b1, LPWT_OFS_CMP, 16'h0004, 16'h0004},
    '{1'b0, LPWT_OFS_PERIOD, 16'h0020, 16'h0010},
    '{1'b1, LPWT_OFS_CMP, 16'h0030, 16'h0004},
    '{1'b1, LPWT_OFS_WAKE, 16'h8000, 16'h8000},
    '{1'b1, LPWT_OFS_CTRL1, 16'h0011, 16'h0011}};

  lpwt_if lk();
  lpwt_timer lpwt_timer_i (.pclk(pclk), .presetn(presetn), .link(lk),
    .sub_osc(sub_osc), .wdt_osc(wdt_osc), .count_value(count_value));
  lpwt_ctrl lpwt_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .event_out(event_out), .link(lk));
  lpwt_chk lpwt_chk_i (.pclk(pclk), .presetn(presetn), .wr_en(lk.wr_en),
    .addr(lk.addr), .wr_data(lk.wr_data), .rd_data(lk.rd_data),
    .protect_en(lk.protect_en), .power_state(lk.power_state),
    .wdt_halt(lk.wdt_halt), .src_tick(lk.src_tick),
    .cmp_event(lk.cmp_event), .wake_req(lk.wake_req));

  // Clock, 25 ns
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  // Slow oscillators, periods of 8 and 6 clocks
  always @(posedge pclk) begin
    ocnt <= ocnt + 1;
    if (ocnt % 4 == 3) sub_osc <= ~sub_osc;
    if (ocnt % 3 == 2) wdt_osc <= ~wdt_osc;
  end

  // ****************
  // Tasks
  // ****************
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; an idle edge first keeps psel single-driven
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  task tw(input logic [7:0] o, input logic [15:0] d);
    apb(1, LPWT_APB_TADDR, {24'h0, o});
    apb(1, LPWT_APB_TDATA, {16'h0, d});
  endtask : tw

  // Read waits out the link write and read latency
  task tr(input logic [7:0] o);
    apb(1, LPWT_APB_TADDR, {24'h0, o});
    repeat (3) @(posedge pclk);
    apb(0, LPWT_APB_TDATA, 32'h0);
    rv = rdat[15:0];
  endtask : tr

  task sys(input logic p, input logic [1:0] m, input logic h);
    apb(1, LPWT_APB_SYS, {28'h0, h, m, p});
  endtask : sys

  task give_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  // Hang guard, well past the expected run
  initial begin
    #(25 * 30000);
    n_mismatch++;
    give_verdict;
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    int ch, tk, wr, n;
    logic [15:0] pv;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    // Register rows
    foreach (rows[i]) begin
      sys(rows[i].p, LPWT_NORMAL, 1'b0);
      tw(rows[i].o, rows[i].w);
      tr(rows[i].o);
      chk(rv, rows[i].e);
    end
    $display("test register rows done");
    // Enable while still stopped is ignored
    tw(LPWT_OFS_CTRL3, 16'h0001);
    repeat (100) @(posedge pclk);
    chk(count_value, 0);
    tw(LPWT_OFS_CTRL2, 16'h0000);
    tw(LPWT_OFS_CTRL3, 16'h0001);
    // Step by one per four ticks, wrap after the period
    ch = 0;
    tk = 0;
    wr = 0;
    pv = count_value;
    repeat (2000) begin
      @(posedge pclk);
      if (lk.src_tick === 1'b1) tk++;
      if (count_value !== pv) begin
        if (ch > 0) chk(tk, 4);
        if (ch > 0) chk(count_value, pv == 16'h10 ? 0 : pv + 1);
        if (pv == 16'h10) wr++;
        ch++;
        tk = 0;
        pv = count_value;
      end
    end
    chk(wr > 1, 1);
    $display("test counting done");
    // Standby wakeup through the event path
    apb(1, LPWT_APB_ELSEL, 32'h0000005d);
    apb(1, LPWT_APB_MASK, 32'h1);
    sys(1, LPWT_STANDBY, 0);
    n = 0;
    while (event_out !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    chk(event_out, 1);
    // Standby asked for at once after wake is held back
    sys(1, LPWT_STANDBY, 0);
    apb(0, LPWT_APB_SYS, 32'h0);
    chk(rdat[2:1], LPWT_NORMAL);
    repeat (10) @(posedge pclk);
    apb(0, LPWT_APB_SYS, 32'h0);
    chk(rdat[2:1], LPWT_STANDBY);
    sys(1, LPWT_NORMAL, 0);
    apb(0, LPWT_APB_STAT, 32'h0);
    chk(rdat[1:0], 2'h3);
    chk(irq, 1);
    apb(1, LPWT_APB_STAT, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 0);
    apb(1, LPWT_APB_MASK, 32'h2);
    repeat (2) @(posedge pclk);
    chk(irq, 1);
    apb(1, LPWT_APB_STAT, 32'h2);
    repeat (2) @(posedge pclk);
    chk(irq, 0);
    // No event while awake
    repeat (1500) @(posedge pclk);
    apb(0, LPWT_APB_STAT, 32'h0);
    chk(rdat, 0);
    $display("test wakeup done");
    // Clear while disabled
    tw(LPWT_OFS_CTRL3, 16'h0000);
    tw(LPWT_OFS_CTRL3, 16'h0002);
    repeat (40) @(posedge pclk);
    chk(count_value, 0);
    tr(LPWT_OFS_CTRL3);
    chk(rv, 0);
    $display("test clear done");
    // Watchdog source halted in sleep, then free
    tw(LPWT_OFS_CTRL1, 16'h0019);
    tw(LPWT_OFS_CTRL3, 16'h0001);
    sys(1, LPWT_SLEEP, 1);
    repeat (10) @(posedge pclk);
    pv = count_value;
    repeat (300) @(posedge pclk);
    chk(count_value, pv);
    sys(1, LPWT_SLEEP, 0);
    repeat (300) @(posedge pclk);
    chk(count_value !== pv, 1);
    $display("test sleep source done");
    // Unmapped address is refused
    apb(0, 12'h0f0, 32'h0);
    chk({rerr, rdat}, {1'b1, 32'h0});
    apb(1, 12'h0f0, 32'h1234);
    chk(rerr, 1);
    $display("test unmapped done");
    // Second reset in mid-run
    presetn <= 0;
    repeat (8) @(posedge pclk);
    chk({pready, irq, count_value}, 18'h20000);
    presetn <= 1;
    tr(LPWT_OFS_PERIOD);
    chk(rv, LPWT_RST_PERIOD);
    tr(LPWT_OFS_CMP);
    chk(rv, LPWT_RST_CMP);
    tr(LPWT_OFS_CTRL2);
    chk(rv, 16'h0001);
    $display("test reset done");
    give_verdict;
  end
endmodule : lpwt_test
